/* edc_pkg.sv */
// Purpose: Shared constants and carrier types for the ECC DRAM/flash controller
// Assumes: 25 MHz system clock, processor bus timed in system clocks
// Notes:   Latencies are first-beat and later-beat counts in clocks

package edc_pkg;

    // ********************************************************************
    // Clock and timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 40;           // System clock period

    // Fast-page DRAM beat counts
    localparam logic [7:0] FP_RD_IDLE    = 8'h09;  // First beat from idle
    localparam logic [7:0] FP_RD_B2      = 8'h01;  // Aligned second beat
    localparam logic [7:0] FP_RD_B3      = 8'h02;  // Aligned third beat
    localparam logic [7:0] FP_RD_B4      = 8'h01;  // Aligned fourth beat
    localparam logic [7:0] FP_MIS_B2     = 8'h03;  // Misaligned second beat
    localparam logic [7:0] FP_MIS_B3     = 8'h01;  // Misaligned third and fourth beats
    localparam logic [7:0] FP_RD1_MISS   = 8'h08;  // Single read after read, miss
    localparam logic [7:0] FP_RD1_HIT    = 8'h06;  // Single read after read, hit
    localparam logic [7:0] FP_WR1_MISS   = 8'h0c;  // Single write after write, miss
    localparam logic [7:0] FP_WR1_HIT    = 8'h0a;  // Single write after write, hit
    localparam logic [7:0] FP_RD4_MISS   = 8'h07;  // Burst read after burst, miss
    localparam logic [7:0] FP_RD4_HIT    = 8'h03;  // Burst read after burst, hit
    // EDO DRAM beat counts
    localparam logic [7:0] EDO_RD_IDLE   = 8'h08;  // First beat from idle
    localparam logic [7:0] EDO_MIS_B2    = 8'h02;  // Misaligned second beat
    localparam logic [7:0] EDO_RD4_MISS  = 8'h05;  // Burst read after burst, miss
    localparam logic [7:0] EDO_RD4_HIT   = 8'h02;  // Burst read after burst, hit
    localparam logic [7:0] EDO_RD1_MISS  = 8'h07;  // Single read after read, miss
    localparam logic [7:0] EDO_RD1_HIT   = 8'h05;  // Single read after read, hit
    // Writes, both part types
    localparam logic [7:0] WR_IDLE       = 8'h04;  // First write beat from idle
    localparam logic [7:0] BEAT_ONE      = 8'h01;  // Streaming beat
    // Flash beat counts
    localparam logic [7:0] FL_RD_FIRST   = 8'h44;  // 68 clocks
    localparam logic [7:0] FL_RD_NEXT    = 8'h40;  // 64 clocks
    localparam logic [7:0] FL_RD_BYTE    = 8'h14;  // 20 clocks
    localparam logic [7:0] FL_WR         = 8'h13;  // 19 clocks

    // ********************************************************************
    // Address map
    // ********************************************************************
    localparam logic [31:0] FLASH_BASE   = 32'hff00_0000; // Flash window base
    localparam logic [31:0] VEC_ADDR     = 32'hfff0_0100; // Reset vector address
    localparam logic [31:0] BOOT_BASE    = 32'hfff0_0000; // Protected boot region
    localparam logic [31:0] BOOT_SIZE    = 32'h0001_0000; // 64KB
    localparam int          ROW_LSB      = 12;            // Row field low bit
    localparam int          ROW_W        = 12;            // Row field width
    localparam int          BLK_BIT      = 26;            // Block select bit
    localparam int          BANK_BIT     = 3;             // Interleave bank bit

    // ********************************************************************
    // Carrier types
    // ********************************************************************
    typedef struct packed {
        logic [31:0] addr;   // Byte address
        logic        write;  // Write when set
        logic        burst;  // Four-beat when set
        logic [3:0]  size;   // Bytes for single beat (1..8)
        logic [31:0] wsize;  // Unused width marker
    } edc_req_s;

    typedef struct packed {
        logic [63:0] data;   // Data word
        logic [7:0]  check;  // Check bits
    } edc_word_s;

endpackage : edc_pkg

/* edc_ecc.sv */
// Purpose: SEC-DED code over a 72-bit memory word (64 data, 8 check)
// Assumes: Extended Hamming code, check slots at powers of two plus parity
// Notes:   Pure combinational; used for both encode and decode

`timescale 1ns/100ps
`default_nettype none

module edc_ecc
(
    input  wire logic [63:0] data,       // Data in
    input  wire logic [7:0]  check_in,   // Stored check bits
    output logic      [7:0]  check_out,  // Fresh check bits
    output logic      [63:0] corrected,  // Data after correction
    output logic             single_err, // Corrected single-bit error
    output logic             double_err  // Uncorrectable error
);

    // ********************************************************************
    // Encoder: data bits sit at the non-power-of-two positions 3..71
    // ********************************************************************
    // Check slots hold the XOR of the positions of all set data bits;
    // bit 7 keeps the whole 72-bit word at even parity
    function automatic logic [7:0] edc_code(input logic [63:0] d);
        logic [7:0] c;
        int         n;
        c = 8'h00;
        n = 0;
        for (int q = 3; q < 72; q++)
        begin
            if ((q & (q - 1)) != 0) // Powers of two are check slots
            begin
                if (d[n])
                    c[6:0] = c[6:0] ^ 7'(q);
                n++;
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction : edc_code

    assign check_out = edc_code(data);

    wire [6:0] syn = check_out[6:0] ^ check_in[6:0]; // Position of a lone upset
    wire       par = ^{data, check_in};               // Odd: one bit upset

    // ********************************************************************
    // Correction: flip the data bit whose position matches the syndrome
    // ********************************************************************
    always_comb
    begin
        int n;
        n = 0;
        corrected = data;
        for (int q = 3; q < 72; q++)
        begin
            if ((q & (q - 1)) != 0)
            begin
                if (par && syn == 7'(q))
                    corrected[n] = ~data[n];
                n++;
            end
        end
    end

    // Odd parity is one upset (a check-bit upset flips no data);
    // even parity with a nonzero syndrome is a double upset
    assign single_err = par;
    assign double_err = !par && (syn != 7'h00);

endmodule : edc_ecc

`default_nettype wire

/* edc_ctrl.sv */
// Purpose: Processor-bus DRAM and flash controller timing core
// Assumes: One request at a time; flash writes are always 32 bits wide
// Notes:   Beat acks follow fixed clock counts per access type

`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Interleave DRAM two ways on address bit
// - 72-bit ECC, correct single, flag double
// - One or two nine-device blocks, page/EDO
// - Fast-page burst read 9,1,2,1 or 9,3,1,1
// - Pipelined page hit shortens first beat
// - Burst write 4,1,1,1 for both parts
// - Single read 9, single write 4
// - Back-to-back singles 12/10 and 8/6
// - EDO burst read 8,1,1,1; single 8
// - Strap maps reset vector to socket bank
// - 64KB boot region write-protected by jumper while strap clear
// - Flash burst read 68,64,64,64; no burst writes
// - Flash singles 68, 20 byte, write 19
module edc_ctrl
#(
    parameter bit TWO_BLOCKS = 1'b1  // Second block populated
)
(
    input  wire logic                  clk,          // System clock
    input  wire logic                  reset,        // Async reset, high
    input  wire logic                  req,          // Transfer start
    input  wire edc_pkg::edc_req_s     req_info,     // Request fields
    input  wire logic                  pipelined,    // Start issued early
    input  wire logic                  edo_a,        // Block A uses EDO parts
    input  wire logic                  edo_b,        // Block B uses EDO parts
    input  wire logic                  vec_strap,    // Reset vector in socket bank
    input  wire logic                  boot_protect, // Boot region jumper fitted
    input  wire edc_pkg::edc_word_s    mem_rdata,    // Word from DRAM
    output logic                       busy,         // Transfer in progress
    output logic                       beat_ack,     // One pulse per beat
    output logic                       err_ack,      // Refused transfer
    output logic [63:0]                rdata,        // Corrected read data
    output logic                       ecc_single,   // Single error corrected
    output logic                       ecc_double,   // Double error seen
    output logic                       dram_sel_b,   // Block B selected
    output logic                       dram_bank,    // Interleave bank
    output logic                       flash_sock,   // Socket bank selected
    output logic [7:0]                 wr_check      // Check bits for writes
);

    // ********************************************************************
    // State and decode
    // ********************************************************************
    typedef enum logic [1:0]
    {
        EDC_IDLE = 2'b00,
        EDC_RUN  = 2'b01
    } edc_state_e;

    edc_state_e            state;        // Current state
    edc_pkg::edc_req_s     cur;          // Latched request
    logic [7:0]            cnt;          // Clocks left in beat
    logic [1:0]            beat;         // Beat index
    logic                  is_flash;     // Current is flash
    logic                  cur_edo;      // Current block part type
    logic                  prev_rd;      // Last access type read
    logic                  prev_burst;   // Last access was burst
    logic                  after_idle;   // No access in pipeline
    logic [11:0]           open_row [2]; // Open row per block
    logic [1:0]            row_valid;    // Row open per block

    wire is_fl  = req_info.addr >= edc_pkg::FLASH_BASE;
    wire blk    = TWO_BLOCKS & req_info.addr[edc_pkg::BLK_BIT];
    wire edo    = blk ? edo_b : edo_a;
    wire [11:0] row = req_info.addr[edc_pkg::ROW_LSB +: edc_pkg::ROW_W];
    wire hit    = row_valid[blk] && open_row[blk] == row;
    wire mis    = req_info.addr[4:3] != 2'b00;  // Quad-word misaligned
    wire in_boot = req_info.addr >= edc_pkg::BOOT_BASE &&
                   req_info.addr < edc_pkg::BOOT_BASE + edc_pkg::BOOT_SIZE;
    // Writes refused: flash bursts, and boot region under jumper with strap clear
    wire refuse = is_fl && req_info.write &&
                  (req_info.burst || (boot_protect && in_boot && !vec_strap));
    wire same   = !after_idle && pipelined && prev_rd == !req_info.write &&
                  prev_burst == req_info.burst;

    // First-beat clocks for a new request
    function automatic logic [7:0] first_beat(input logic fl, input logic e,
                                               input logic s, input logic h);
        if (fl)
            return req_info.write ? edc_pkg::FL_WR :
                   (!req_info.burst && req_info.size == 4'h1) ?
                   edc_pkg::FL_RD_BYTE : edc_pkg::FL_RD_FIRST;
        if (req_info.write && !s)
            return edc_pkg::WR_IDLE;
        if (req_info.write)
            return h ? edc_pkg::FP_WR1_HIT : edc_pkg::FP_WR1_MISS;
        if (!s)
            return e ? edc_pkg::EDO_RD_IDLE : edc_pkg::FP_RD_IDLE;
        if (req_info.burst)
            return e ? (h ? edc_pkg::EDO_RD4_HIT : edc_pkg::EDO_RD4_MISS)
                     : (h ? edc_pkg::FP_RD4_HIT : edc_pkg::FP_RD4_MISS);
        return e ? (h ? edc_pkg::EDO_RD1_HIT : edc_pkg::EDO_RD1_MISS)
                 : (h ? edc_pkg::FP_RD1_HIT : edc_pkg::FP_RD1_MISS);
    endfunction : first_beat

    // Later-beat clocks given beat index now finishing
    wire [7:0] next_beat =
        is_flash ? edc_pkg::FL_RD_NEXT :
        cur.write ? edc_pkg::BEAT_ONE :
        (cur.addr[4:3] != 2'b00) ?
            (beat == 2'd0 ? (cur_edo ? edc_pkg::EDO_MIS_B2 : edc_pkg::FP_MIS_B2)
                          : edc_pkg::FP_MIS_B3) :
        cur_edo ? edc_pkg::BEAT_ONE :
        (beat == 2'd0 ? edc_pkg::FP_RD_B2 :
         beat == 2'd1 ? edc_pkg::FP_RD_B3 : edc_pkg::FP_RD_B4);

    wire start = state == EDC_IDLE && req;
    wire done  = state == EDC_RUN && cnt == 8'h01 &&
                 (!cur.burst || beat == 2'd3);

    // ********************************************************************
    // ECC
    // ********************************************************************
    logic [63:0] corr;
    logic        s_err;
    logic        d_err;
    logic [7:0]  chk_calc;  // Check bits ahead of the output flop

    edc_ecc u_ecc
    (
        .data       (mem_rdata.data),
        .check_in   (mem_rdata.check),
        .check_out  (chk_calc),
        .corrected  (corr),
        .single_err (s_err),
        .double_err (d_err)
    );

    // ********************************************************************
    // Sequencer
    // ********************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state      <= EDC_IDLE;
            cur        <= '0;
            cnt        <= 8'h00;
            beat       <= 2'd0;
            is_flash   <= 1'b0;
            cur_edo    <= 1'b0;
            busy       <= 1'b0;
            beat_ack   <= 1'b0;
            err_ack    <= 1'b0;
            rdata      <= 64'h0;
            ecc_single <= 1'b0;
            ecc_double <= 1'b0;
            dram_sel_b <= 1'b0;
            dram_bank  <= 1'b0;
            flash_sock <= 1'b0;
            wr_check   <= 8'h00;
            prev_rd    <= 1'b0;
            prev_burst <= 1'b0;
            after_idle <= 1'b1;
            row_valid  <= 2'b00;
            open_row[0] <= 12'h000;
            open_row[1] <= 12'h000;
        end
        else
        begin
            beat_ack <= 1'b0;
            wr_check <= chk_calc;  // Registered so the port is a flop
            err_ack  <= start && refuse;
            // Pipeline lapses if the master lets a cycle pass idle
            if (state == EDC_IDLE && !req)
                after_idle <= 1'b1;
            if (start && !refuse)
            begin
                state      <= EDC_RUN;
                cur        <= req_info;
                cnt        <= first_beat(is_fl, edo, same, hit);
                beat       <= 2'd0;
                is_flash   <= is_fl;
                cur_edo    <= edo;
                busy       <= 1'b1;
                dram_sel_b <= blk;
                dram_bank  <= req_info.addr[edc_pkg::BANK_BIT];
                // Vector address goes to sockets under the strap
                flash_sock <= is_fl && vec_strap &&
                              req_info.addr[31:20] == edc_pkg::VEC_ADDR[31:20];
                if (!is_fl)
                begin
                    open_row[blk]  <= row;
                    row_valid[blk] <= 1'b1;
                end
            end
            else if (state == EDC_RUN)
            begin
                if (cnt == 8'h01)
                begin
                    beat_ack <= 1'b1;
                    if (!cur.write && !is_flash)
                    begin
                        rdata      <= corr;
                        ecc_single <= s_err;
                        ecc_double <= d_err;
                    end
                    if (done)
                    begin
                        state      <= EDC_IDLE;
                        busy       <= 1'b0;
                        prev_rd    <= !cur.write;
                        prev_burst <= cur.burst;
                        after_idle <= 1'b0;
                    end
                    else
                    begin
                        cnt       <= next_beat;
                        beat      <= beat + 2'd1;
                        dram_bank <= ~dram_bank;
                    end
                end
                else
                    cnt <= cnt - 8'h01;
            end
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    sequence s_idle_wr;
        start && !refuse && !is_fl && req_info.write && !same;
    endsequence

    a_write_first: assert property (@(posedge clk) disable iff (reset)
        s_idle_wr |=> !beat_ack[*4] ##1 beat_ack)
        else $error("Idle write first beat not at four clocks");

    a_fp_read_idle: assert property (@(posedge clk) disable iff (reset)
        start && !refuse && !is_fl && !req_info.write && !same && !edo
        |=> !beat_ack[*8] ##1 !beat_ack ##1 beat_ack)
        else $error("Fast-page idle read not at nine clocks");

    a_edo_read_idle: assert property (@(posedge clk) disable iff (reset)
        start && !refuse && !is_fl && !req_info.write && !same && edo
        |=> !beat_ack[*8] ##1 beat_ack)
        else $error("EDO idle read not at eight clocks");

    a_flash_write: assert property (@(posedge clk) disable iff (reset)
        start && !refuse && is_fl && req_info.write
        |=> ##19 beat_ack)
        else $error("Flash write not at nineteen clocks");

    a_flash_byte: assert property (@(posedge clk) disable iff (reset)
        start && !refuse && is_fl && !req_info.write && !req_info.burst &&
        req_info.size == 4'h1 |=> ##20 beat_ack)
        else $error("Flash byte read not at twenty clocks");

    a_flash_burst: assert property (@(posedge clk) disable iff (reset)
        start && is_fl && req_info.write && req_info.burst |=> err_ack && !busy)
        else $error("Flash burst write not refused");

    a_bank_swap: assert property (@(posedge clk) disable iff (reset)
        beat_ack && busy |-> dram_bank != $past(dram_bank))
        else $error("Interleave bank did not alternate");

    a_boot_guard: assert property (@(posedge clk) disable iff (reset)
        start && is_fl && req_info.write && boot_protect && in_boot && !vec_strap
        |=> err_ack)
        else $error("Protected boot write accepted");

    a_single_err: assert property (@(posedge clk) disable iff (reset)
        beat_ack && !cur.write && !is_flash |-> ecc_single == $past(s_err))
        else $error("Single error flag not captured");

endmodule : edc_ctrl

`default_nettype wire

/* edc_mem_model.sv */
// Purpose: Memory-side model that returns a stored code word to the controller
// Assumes: Array was filled through an extended Hamming write path
// Notes:   A flip mask injects data-bit upsets on the way back

`timescale 1ns/100ps
`default_nettype none

module edc_mem_model
(
    input  wire logic [63:0]       store_data, // Word held in the array
    input  wire logic [63:0]       flip,       // Bits upset while stored
    input  wire logic              busy,       // Controller in a transfer
    output var edc_pkg::edc_word_s mem_rdata   // Word back to controller
);
    // ****************************************
    // Stored code word
    // ****************************************
    // Write path: data at non-power-of-two positions 3..71, bit 7 parity
    function automatic logic [7:0] fill_code(input logic [63:0] d);
        logic [7:0] c;
        int         n;
        c = 8'h00;
        n = 0;
        for (int q = 3; q < 72; q++)
        begin
            if ((q & (q - 1)) != 0)
            begin
                if (d[n])
                    c[6:0] = c[6:0] ^ 7'(q);
                n++;
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction : fill_code

    wire [7:0] chk = fill_code(store_data); // Check bits as written

    // Idle bus is not driven: show the inverse, never the old word
    assign mem_rdata = busy ? {store_data ^ flip, chk} : {~store_data, ~chk};
endmodule : edc_mem_model

`default_nettype wire

/* edc_ctrl_tb.sv */
// Purpose: Self-checking bench for the DRAM and flash timing core
// Assumes: Beat gaps counted from the edge that takes the request
// Notes:   Inputs change 1 ns after the rising edge

`timescale 1ns/100ps
`default_nettype none

module edc_ctrl_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic               clk;                       // System clock
    logic               reset;                     // Async reset
    logic               req;                       // Transfer start
    edc_pkg::edc_req_s  req_info;                  // Request fields
    logic               pipelined, edo_a, edo_b;   // Master and part type
    logic               vec_strap, boot_protect;   // Board straps
    edc_pkg::edc_word_s mem_rdata;                 // Word from model
    logic               busy, beat_ack, err_ack;   // Handshake outputs
    logic               ecc_single, ecc_double;    // Error flags
    logic               dram_sel_b, dram_bank;     // DRAM steering
    logic               flash_sock;                // Socket bank select
    logic [63:0]        rdata;                     // Corrected data
    logic [7:0]         wr_check;                  // Judged mid-burst
    logic [63:0]        store_data;                // Word in memory
    logic [63:0]        flip;                      // Injected upsets
    logic [1:0]         bank_seen;                 // Bank at beats 1, 2
    logic               sock_seen, selb_seen;      // Steering at beat 1
    int                 error_cnt = 0;
    int                 n_tests = 0;
    int                 cyc = 0;

    edc_ctrl #(.TWO_BLOCKS(1'b1)) dut_u (.clk(clk), .reset(reset), .req(req),
        .req_info(req_info), .pipelined(pipelined), .edo_a(edo_a), .edo_b(edo_b),
        .vec_strap(vec_strap), .boot_protect(boot_protect), .mem_rdata(mem_rdata),
        .busy(busy), .beat_ack(beat_ack), .err_ack(err_ack), .rdata(rdata),
        .ecc_single(ecc_single), .ecc_double(ecc_double), .dram_sel_b(dram_sel_b),
        .dram_bank(dram_bank), .flash_sock(flash_sock), .wr_check(wr_check));
    edc_mem_model mem_u (.store_data(store_data), .flip(flip), .busy(busy),
        .mem_rdata(mem_rdata));

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial clk = 1'b0;
    always #20 clk = ~clk;
    // Whole run is under 2000 cycles; a hang is cut off well past that
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // Kind is {write, burst}; gaps packed one byte a beat, first beat lowest
    task automatic xfer(input logic [31:0] a, input logic [1:0] kind,
                        input logic [3:0] sz, input logic [31:0] gaps);
        int c;
        req_info = '{addr: a, write: kind[1], burst: kind[0], size: sz, wsize: 32'h0};
        req = 1'b1;
        @(posedge clk);
        #1 req = 1'b0;
        for (int k = 0; k < (kind[0] ? 4 : 1); k++)
        begin
            c = 0;
            do
            begin
                @(posedge clk);
                #1 c++;
            end while (beat_ack !== 1'b1 && c < 300);
            check(64'(c), 64'(gaps[8*k +: 8]));
            if (k < 2)
                bank_seen[k] = dram_bank;
            if (k == 0 && kind == 2'h1)
                check(wr_check, mem_rdata.check);
            if (k == 0)
                {sock_seen, selb_seen} = {flash_sock, dram_sel_b};
        end
    endtask : xfer

    // Refused write: err_ack for one cycle, busy never rises
    task automatic refuse(input logic [31:0] a, input logic bst);
        req_info = '{addr: a, write: 1'b1, burst: bst, size: 4'h4, wsize: 32'h0};
        req = 1'b1;
        @(posedge clk);
        #1 req = 1'b0;
        check({err_ack, busy}, 64'h2);
        idle(1);
        check(err_ack, 64'h0);
    endtask : refuse

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_dram();
        xfer(32'h0000_1000, 2'h0, 4'h8, 32'h09);
        check(rdata, store_data);
        check(selb_seen, 64'h0);
        idle(2);
        xfer(32'h0000_1000, 2'h2, 4'h8, 32'h04);
        idle(2);
        xfer(32'h0000_2000, 2'h1, 4'h8, 32'h01020109);
        check(bank_seen[1] ^ bank_seen[0], 64'h1);
        idle(2);
        xfer(32'h0000_2008, 2'h1, 4'h8, 32'h01010309);
        idle(2);
        xfer(32'h0000_2000, 2'h3, 4'h8, 32'h01010104);
        $display("dram fast-page idle timing done");
    endtask : t_dram

    task automatic t_edo();
        edo_a = 1'b1;
        idle(2);
        xfer(32'h0000_2000, 2'h3, 4'h8, 32'h01010104);
        idle(2);
        xfer(32'h0000_2000, 2'h1, 4'h8, 32'h01010108);
        edo_b = 1'b1;
        idle(2);
        xfer(32'h0400_0000, 2'h0, 4'h8, 32'h08);
        check(selb_seen, 64'h1);
        {edo_a, edo_b} = 2'h0;
        $display("dram edo timing done");
    endtask : t_edo

    task automatic t_b2b();
        pipelined = 1'b1;
        idle(2);
        xfer(32'h0000_3000, 2'h0, 4'h8, 32'h09);
        xfer(32'h0000_5000, 2'h0, 4'h8, 32'h08);
        xfer(32'h0000_5008, 2'h0, 4'h8, 32'h06);
        xfer(32'h0000_7000, 2'h2, 4'h8, 32'h04);
        xfer(32'h0000_9000, 2'h2, 4'h8, 32'h0c);
        xfer(32'h0000_9010, 2'h2, 4'h8, 32'h0a);
        idle(2);
        xfer(32'h0000_3000, 2'h1, 4'h8, 32'h01020109);
        xfer(32'h0000_6000, 2'h1, 4'h8, 32'h01020107);
        xfer(32'h0000_6020, 2'h1, 4'h8, 32'h01020103);
        pipelined = 1'b0;
        $display("back-to-back page hit and miss done");
    endtask : t_b2b

    task automatic t_ecc();
        idle(2);
        flip = 64'h0000_0000_0001_0000;
        xfer(32'h0000_1000, 2'h0, 4'h8, 32'h09);
        check(rdata, store_data);
        check({ecc_double, ecc_single}, 64'h1);
        idle(2);
        flip = 64'h0000_0000_0003_0000;
        xfer(32'h0000_1000, 2'h0, 4'h8, 32'h09);
        check({ecc_double, ecc_single}, 64'h2);
        flip = 64'h0;
        $display("ecc correct and detect done");
    endtask : t_ecc

    task automatic t_flash();
        idle(2);
        xfer(32'hff80_0000, 2'h1, 4'h8, 32'h40404044);
        idle(2);
        xfer(32'hff80_0000, 2'h0, 4'h8, 32'h44);
        idle(2);
        xfer(32'hff80_0001, 2'h0, 4'h1, 32'h14);
        idle(2);
        xfer(32'hff80_0000, 2'h2, 4'h4, 32'h13);
        idle(2);
        refuse(32'hff80_0000, 1'b1);
        $display("flash timing done");
    endtask : t_flash

    task automatic t_boot();
        boot_protect = 1'b1;
        idle(2);
        refuse(32'hfff0_0000, 1'b0);
        vec_strap = 1'b1;
        idle(2);
        xfer(32'hfff0_0100, 2'h0, 4'h8, 32'h44);
        check(sock_seen, 64'h1);
        vec_strap = 1'b0;
        idle(2);
        xfer(32'hfff0_0100, 2'h0, 4'h8, 32'h44);
        check(sock_seen, 64'h0);
        boot_protect = 1'b0;
        idle(2);
        xfer(32'hfff0_0000, 2'h2, 4'h4, 32'h13);
        $display("boot region and vector strap done");
    endtask : t_boot

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        reset = 1'b1;
        req = 1'b0;
        req_info = '0;
        {pipelined, edo_a, edo_b, vec_strap, boot_protect} = 5'h0;
        store_data = 64'h0123_4567_89ab_cdef;
        flip = 64'h0;
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        t_dram();
        t_edo();
        t_b2b();
        t_ecc();
        t_flash();
        t_boot();
        stop_test();
    end
endmodule : edc_ctrl_tb

`default_nettype wire
